// ---- inc/flash_status_consts.vh ----
// Purpose: constants of the serial flash status register block
// Assumes: included by the bare name from the design file
// Notes:   codes not fixed here are parameters of the top module
`ifndef FLASH_STATUS_CONSTS_VH
`define FLASH_STATUS_CONSTS_VH

// command codes
`define REGISTER_WRITE_CMD     8'h01
`define WRITE_PERMIT_CLEAR_CMD 8'h04
`define STATUS_READ_CMD        8'h05
`define WRITE_PERMIT_SET_CMD   8'h06
`define ERROR_CLEAR_CMD        8'h30

// bit positions in flash_status_one
`define LOCK_POS      7
`define PROG_ERR_POS  6
`define ERASE_ERR_POS 5
`define PROT_HI_POS   4
`define PROT_LO_POS   2
`define PERMIT_POS    1
`define BUSY_POS      0

// reset and default values
`define LOCK_RST      1'b0
`define ERR_RST       1'b0
`define PERMIT_RST    1'b0
`define PROT_VOL_DEF  3'h7
`define PROT_RST      3'h0

// frame bit counts
`define OPCODE_BITS   5'h08
`define REGW_BITS     5'h10

// operation kinds, one-hot
`define KIND_PROG     4'h1
`define KIND_ERASE    4'h2
`define KIND_WHOLE    4'h4
`define KIND_REGW     4'h8

`endif

// ---- hw/flash_status_register.v ----
// Purpose: status register one of a serial flash with its command handling
// Assumes: spi mode 0, pins sampled by sys_clk; array engine on sys_clk
// Notes:   array engine reports op_done, op_fail, op_prot_hit as pulses
//
// What this block does
// (RL1) Status read code 05h shifts the status register to the host.
// (RL2) Resets load volatile bits with defaults; nonvolatile bits keep value.
// (RL3) Lock bit set and write-protect low: lock, range bits frozen.
// (RL4) Pin high or lock clear lets register write change lock and range.
// (RL5) Program failure or protected program target sets program failure flag.
// (RL6) Single erase failure or protected single erase target sets erase flag.
// (RL7) Whole-array erase hitting protected sector leaves erase flag clear.
// (RL8) Error clear 30h clears both flags; register write cannot touch them.
// (RL9) Range bits volatile, default ones, when volatility select is 1.
// (RL10) Any range bit set protects area; whole erase needs all zero.
// (RL11) Write permit set 06h sets latch; writes need latch set.
// (RL12) Register write, program, erase ignored while latch is clear.
// (RL13) Write permit clear 04h clears the latch.
// (RL14) Successful operation end clears latch; register write data leaves it.
// (RL15) Host sends error clear, then write permit clear, after failure.
// (RL16) Latch forced to zero by power cycle, hardware or software reset.
// (RL17) While busy only reads, pauses, error clear, software reset accepted.
// (RL18) Pause accepted only while matching array operation runs.
// (RL19) Failure keeps busy set until an error clear or software reset arrives.
// (RL20) Register write 01h writes lock and range bits, if permitted.
// (RL21) Status read shifts msb first, repeating while host keeps clocking.
`include "flash_status_consts.vh"
`timescale 1ns/10ps

module flash_status_register #(
	parameter [7:0] STATUS_TWO_READ_CMD   = 8'he1,
	parameter [7:0] PROGRAM_CMD           = 8'he2,
	parameter [7:0] SECTOR_ERASE_CMD      = 8'he3,
	parameter [7:0] WHOLE_ARRAY_ERASE_CMD = 8'he4,
	parameter [7:0] ERASE_PAUSE_CMD       = 8'he5,
	parameter [7:0] PROGRAM_PAUSE_CMD     = 8'he6,
	parameter [7:0] SOFT_RESET_CMD        = 8'he7
) (
	input  wire       sys_clk,
	input  wire       resetn,
	input  wire       spi_sck,
	input  wire       spi_cs_n,
	input  wire       spi_si,
	input  wire       wp_n,
	output reg        spi_so,
	output reg        spi_so_oe,
	input  wire       prot_volatility_select,
	input  wire       nv_lock_in,
	input  wire [2:0] nv_prot_in,
	input  wire       op_done,
	input  wire       op_fail,
	input  wire       op_prot_hit,
	output reg        start_program,
	output reg        start_erase,
	output reg        start_whole_erase,
	output reg        start_reg_write,
	output reg        reg_write_lock,
	output reg  [2:0] reg_write_prot,
	output reg        pause_erase,
	output reg        pause_program,
	output reg        soft_reset_pulse,
	output reg  [7:0] flash_status_one
);

	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_RUN  = 3'h2;
	localparam [2:0] ST_ERR  = 3'h4;

	// commands that stay legal while busy
	function busy_ok;
		input [7:0] code;
		begin
			busy_ok = (code == `STATUS_READ_CMD) ||
				(code == STATUS_TWO_READ_CMD) ||
				(code == ERASE_PAUSE_CMD) ||
				(code == PROGRAM_PAUSE_CMD) ||
				(code == `ERROR_CLEAR_CMD) ||
				(code == SOFT_RESET_CMD);
		end
	endfunction

	function is_read;
		input [7:0] code;
		begin
			is_read = (code == `STATUS_READ_CMD) ||
				(code == STATUS_TWO_READ_CMD);
		end
	endfunction

	// pin synchronisers: {wp_n, cs_n, sck, si}
	// reset to wp_n, cs_n and sck high, si low; high cs_n masks the sck edges that follow reset
	localparam [3:0] PIN_IDLE = 4'he;
	wire [3:0] pin_sync;
	wire [3:0] pin_raw = {wp_n, spi_cs_n, spi_sck, spi_si};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
			reg meta;
			reg settled;
			always @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					meta    <= PIN_IDLE[gi];
					settled <= PIN_IDLE[gi];
				end else begin
					meta    <= pin_raw[gi];
					settled <= meta;
				end
			end
			assign pin_sync[gi] = settled;
		end
	endgenerate

	wire si_s   = pin_sync[0];
	wire sck_s  = pin_sync[1];
	wire cs_n_s = pin_sync[2];
	wire wp_n_s = pin_sync[3];

	reg sck_prev;
	reg cs_prev;
	wire sck_rise  = sck_s & ~sck_prev & ~cs_n_s;
	wire sck_fall  = ~sck_s & sck_prev & ~cs_n_s;
	wire frame_end = cs_n_s & ~cs_prev;

	// register state
	reg       loaded;
	reg       lock;
	reg       prog_err;
	reg       erase_err;
	reg [2:0] prot;
	reg       permit;
	reg [2:0] state;
	reg [3:0] kind;

	wire busy = (state != ST_IDLE);
	wire [7:0] status_now = {lock, prog_err, erase_err, prot, permit, busy};
	wire hw_locked = lock & ~wp_n_s; // RL3

	// frame receive
	reg [4:0] bit_cnt;
	reg [6:0] shift_in;
	reg [7:0] opcode;
	reg [7:0] data_byte;
	reg       rd_active;
	reg       rd_zero;
	reg [2:0] rd_idx;
	reg [6:0] rd_shift;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sck_prev  <= 1'b0;
			cs_prev   <= 1'b1;
			bit_cnt   <= 5'h00;
			shift_in  <= 7'h00;
			opcode    <= 8'h00;
			data_byte <= 8'h00;
			rd_active <= 1'b0;
			rd_zero   <= 1'b0;
			rd_idx    <= 3'h0;
			rd_shift  <= 7'h00;
			spi_so    <= 1'b0;
			spi_so_oe <= 1'b0;
		end else begin
			sck_prev <= sck_s;
			cs_prev  <= cs_n_s;
			if (cs_n_s) begin
				bit_cnt   <= 5'h00;
				rd_active <= 1'b0;
				rd_idx    <= 3'h0;
				spi_so_oe <= 1'b0;
			end else if (sck_rise) begin
				shift_in <= {shift_in[5:0], si_s};
				if (bit_cnt != `REGW_BITS) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
				if (bit_cnt == `OPCODE_BITS - 5'h01) begin
					opcode <= {shift_in, si_s};
					// RL1
					rd_active <= is_read({shift_in, si_s});
					rd_zero <= ({shift_in, si_s} != `STATUS_READ_CMD);
				end
				if (bit_cnt == `REGW_BITS - 5'h01) begin
					data_byte <= {shift_in, si_s};
				end
			end else if (sck_fall && rd_active) begin
				spi_so_oe <= 1'b1;
				rd_idx <= rd_idx + 3'h1;
				// fresh snapshot at each byte boundary
				if (rd_idx == 3'h0) begin
					spi_so   <= rd_zero ? 1'b0 : status_now[7]; // RL21
					rd_shift <= rd_zero ? 7'h00 : status_now[6:0];
				end else begin
					spi_so   <= rd_shift[6]; // RL21
					rd_shift <= {rd_shift[5:0], 1'b0};
				end
			end
		end
	end

	// one-byte commands run at frame end; register write needs 16 bits
	wire one_byte = frame_end && (bit_cnt == `OPCODE_BITS);
	wire two_byte = frame_end && (bit_cnt == `REGW_BITS);
	wire cmd_ok   = !busy || busy_ok(opcode); // RL17

	wire do_soft_reset = one_byte && (opcode == SOFT_RESET_CMD);
	wire do_err_clear  = one_byte && (opcode == `ERROR_CLEAR_CMD);
	wire do_set_permit = one_byte && cmd_ok &&
		(opcode == `WRITE_PERMIT_SET_CMD);
	wire do_clr_permit = one_byte && cmd_ok &&
		(opcode == `WRITE_PERMIT_CLEAR_CMD);
	wire can_write = !busy && permit; // RL12
	wire do_regw  = two_byte && can_write && !hw_locked && // RL3 RL4
		(opcode == `REGISTER_WRITE_CMD); // RL20
	wire do_prog  = one_byte && can_write && (opcode == PROGRAM_CMD);
	wire do_erase = one_byte && can_write && (opcode == SECTOR_ERASE_CMD);
	wire do_whole = one_byte && can_write && (prot == 3'h0) && // RL10
		(opcode == WHOLE_ARRAY_ERASE_CMD);
	wire do_pause_e = one_byte && (state == ST_RUN) && // RL18
		(kind == `KIND_ERASE || kind == `KIND_WHOLE) &&
		(opcode == ERASE_PAUSE_CMD);
	wire do_pause_p = one_byte && (state == ST_RUN) && // RL18
		(kind == `KIND_PROG) && (opcode == PROGRAM_PAUSE_CMD);

	wire run_end  = (state == ST_RUN) && (op_done || op_fail);
	// protected sectors met by a whole erase are skipped silently
	wire end_ok   = run_end && (op_done ||
		(kind == `KIND_WHOLE && op_prot_hit)); // RL7
	wire end_fail = run_end && !end_ok;
	wire set_perr = end_fail && (kind == `KIND_PROG); // RL5
	wire set_eerr = end_fail && (kind == `KIND_ERASE); // RL6
	wire [3:0] next_kind = do_prog  ? `KIND_PROG  :
		do_erase ? `KIND_ERASE :
		do_whole ? `KIND_WHOLE : `KIND_REGW;
	wire start_any = do_prog || do_erase || do_whole || do_regw;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			loaded    <= 1'b0;
			lock      <= `LOCK_RST;
			prog_err  <= `ERR_RST;
			erase_err <= `ERR_RST;
			prot      <= `PROT_RST;
			permit    <= `PERMIT_RST; // RL16
			state     <= ST_IDLE;
			kind      <= `KIND_PROG;
			reg_write_lock <= `LOCK_RST;
			reg_write_prot <= `PROT_RST;
		end else if (!loaded) begin
			// nonvolatile values caught after reset release
			loaded <= 1'b1;
			lock   <= nv_lock_in; // RL2
			prot   <= prot_volatility_select ? `PROT_VOL_DEF : // RL9
				nv_prot_in;
		end else if (do_soft_reset) begin
			prog_err  <= `ERR_RST; // RL2
			erase_err <= `ERR_RST;
			permit    <= `PERMIT_RST; // RL16
			state     <= ST_IDLE;
			if (prot_volatility_select) begin
				prot <= `PROT_VOL_DEF; // RL9
			end
		end else begin
			// flag set wins over a same-cycle error clear
			prog_err  <= set_perr | (prog_err & ~do_err_clear); // RL8
			erase_err <= set_eerr | (erase_err & ~do_err_clear); // RL8
			if (do_set_permit) begin
				permit <= 1'b1; // RL11
			end else if (do_clr_permit) begin
				permit <= 1'b0; // RL13
			end else if (end_ok) begin
				permit <= 1'b0; // RL14
			end
			if (end_ok && kind == `KIND_REGW) begin
				lock <= reg_write_lock;
				prot <= reg_write_prot;
			end
			if (do_regw) begin
				reg_write_lock <= data_byte[`LOCK_POS];
				reg_write_prot <= data_byte[`PROT_HI_POS:`PROT_LO_POS];
			end
			case (state)
				ST_IDLE: begin
					if (start_any) begin
						state <= ST_RUN;
						kind  <= next_kind;
					end
				end
				ST_RUN: begin
					if (end_ok) begin
						state <= ST_IDLE;
					end else if (end_fail) begin
						state <= do_err_clear ? ST_IDLE : ST_ERR; // RL19
					end
				end
				ST_ERR: begin
					if (do_err_clear) begin
						state <= ST_IDLE; // RL19
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// engine strobes and visible status
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			start_program     <= 1'b0;
			start_erase       <= 1'b0;
			start_whole_erase <= 1'b0;
			start_reg_write   <= 1'b0;
			pause_erase       <= 1'b0;
			pause_program     <= 1'b0;
			soft_reset_pulse  <= 1'b0;
			flash_status_one  <= 8'h00;
		end else begin
			start_program     <= loaded && !do_soft_reset && do_prog;
			start_erase       <= loaded && !do_soft_reset && do_erase;
			start_whole_erase <= loaded && !do_soft_reset && do_whole;
			start_reg_write   <= loaded && !do_soft_reset && do_regw;
			pause_erase       <= loaded && do_pause_e;
			pause_program     <= loaded && do_pause_p;
			soft_reset_pulse  <= loaded && do_soft_reset;
			flash_status_one  <= status_now;
		end
	end

endmodule

// ---- verification/status_monitor.sv ----
// Purpose: port checks of the flash status register
// Assumes: status output lags internal state by one cycle
// Notes:   bound into the design top
`timescale 1ns/10ps
module status_monitor (
	input wire       sys_clk,
	input wire       resetn,
	input wire       spi_cs_n,
	input wire       wp_n,
	input wire       spi_so_oe,
	input wire       start_program,
	input wire       start_erase,
	input wire       start_whole_erase,
	input wire       start_reg_write,
	input wire       pause_erase,
	input wire       pause_program,
	input wire       soft_reset_pulse,
	input wire [7:0] flash_status_one
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire starts = start_program | start_erase | start_whole_erase |
		start_reg_write;
	regw_busy_a:
		assert property (start_reg_write |-> ##[0:2] flash_status_one[0])
		else $error("register write not busy");
	permit_need_a:
		assert property (starts |-> flash_status_one[1])
		else $error("start without permit");
	idle_start_a:
		assert property (starts |-> !flash_status_one[0])
		else $error("start while busy");
	bulk_clear_a:
		assert property (start_whole_erase |-> flash_status_one[4:2] == 3'h0)
		else $error("whole erase with range set");
	hw_lock_a:
		assert property (start_reg_write && !wp_n |-> !flash_status_one[7])
		else $error("write in locked mode");
	err_busy_a:
		assert property ($rose(flash_status_one[6] | flash_status_one[5])
			|-> flash_status_one[0])
		else $error("failure without busy");
	pause_run_a:
		assert property (pause_erase |-> flash_status_one[0])
		else $error("pause while idle");
	prog_pause_a:
		assert property (pause_program |-> flash_status_one[0])
		else $error("program pause while idle");
	soft_clear_a:
		assert property (soft_reset_pulse
			|=> flash_status_one[6:5] == 2'h0
			&& flash_status_one[1:0] == 2'h0)
		else $error("soft reset left permit, error or busy");
	oe_off_a:
		assert property ($rose(spi_cs_n) |-> ##[1:5] !spi_so_oe)
		else $error("so driven after deselect");
endmodule
bind flash_status_register status_monitor mon_u (.*);

// ---- verification/spi_host.sv ----
// Purpose: host side spi controller model, mode 0
// Assumes: sck low 300 ns, high 100 ns, period 400 ns
// Notes:   so sampled late in the low phase
`timescale 1ns/10ps
module spi_host (
	input  wire  sys_clk,
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_si,
	input  wire  spi_so
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// sends the top n bits of d, msb first; pins move on sys_clk falls
	task automatic xfer(input logic [15:0] d, input int n,
		output logic [7:0] r);
		@(negedge sys_clk);
		spi_cs_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			repeat (3) @(negedge sys_clk);
			spi_si = d[i];
			repeat (3) @(negedge sys_clk);
			r = {r[6:0], spi_so};
			spi_sck = 1'b1;
			repeat (2) @(negedge sys_clk);
			spi_sck = 1'b0;
		end
		repeat (6) @(negedge sys_clk);
		spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule

// ---- verification/serial_flash_status_register_tb.sv ----
// Purpose: command level test of the flash status register
// Assumes: status read via spi, engine replies driven here
// Notes:   opcodes e1..e7 follow the design defaults
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module serial_flash_status_register_tb;
	logic       sys_clk = 1'b0;
	logic       resetn = 1'b0;
	logic       wp_n = 1'b0;
	logic       prot_volatility_select = 1'b1;
	logic       nv_lock_in = 1'b0;
	logic [2:0] nv_prot_in = 3'h0;
	logic       op_done = 1'b0;
	logic       op_fail = 1'b0;
	logic       op_prot_hit = 1'b0;
	wire        spi_sck;
	wire        spi_cs_n;
	wire        spi_si;
	wire        spi_so;
	wire        spi_so_oe;
	// released line shows the inverse of the last driven bit
	wire        so_line = spi_so_oe ? spi_so : ~spi_so;
	wire        start_program;
	wire        start_erase;
	wire        start_whole_erase;
	wire        start_reg_write;
	wire        reg_write_lock;
	wire [2:0]  reg_write_prot;
	wire        pause_erase;
	wire        pause_program;
	wire        soft_reset_pulse;
	wire [7:0]  flash_status_one;
	int         n_starts = 0;
	int         n_pe = 0;
	int         n_pp = 0;
	int         n_sr = 0;
	logic [7:0] r;
	int         n_errors = 0;
	int         num_checks = 0;
	int         cyc = 0;
	always #25 sys_clk = ~sys_clk;
	flash_status_register dut_u (.*);
	spi_host host_u (.sys_clk(sys_clk), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(so_line));
	// engine strobe counters
	always @(posedge sys_clk) begin
		if (start_program | start_erase | start_whole_erase |
			start_reg_write) begin
			n_starts++;
		end
		if (pause_erase) begin
			n_pe++;
		end
		if (pause_program) begin
			n_pp++;
		end
		if (soft_reset_pulse) begin
			n_sr++;
		end
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic cmd(input logic [7:0] c);
		host_u.xfer({c, 8'h00}, 8, r);
	endtask
	task automatic wr(input logic [7:0] d);
		host_u.xfer({8'h01, d}, 16, r);
	endtask
	task automatic rd(input logic [7:0] e);
		host_u.xfer({8'h05, 8'h00}, 16, r);
		`CHK(r, e)
	endtask
	task automatic eng(input logic f, input logic p);
		@(negedge sys_clk);
		op_done = ~f;
		op_fail = f;
		op_prot_hit = p;
		@(negedge sys_clk);
		{op_done, op_fail, op_prot_hit} = 3'h0;
		repeat (4) @(negedge sys_clk);
	endtask
	task automatic rst(input logic v, input logic [2:0] p);
		@(negedge sys_clk);
		resetn = 1'b0;
		prot_volatility_select = v;
		nv_prot_in = p;
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (6) @(negedge sys_clk);
	endtask
	initial begin
		rst(1'b1, 3'h0);
		rd(8'h1c);
		`CHK(flash_status_one, 8'h1c)
		rst(1'b0, 3'h2);
		rd(8'h08);
		wr(8'h9c);
		rd(8'h08);
		cmd(8'h06);
		rd(8'h0a);
		cmd(8'h04);
		rd(8'h08);
		cmd(8'h06);
		cmd(8'he4);
		rd(8'h0a);
		wr(8'h80);
		rd(8'h0b);
		`CHK({reg_write_lock, reg_write_prot}, 4'h8)
		eng(1'b0, 1'b0);
		rd(8'h80);
		@(negedge sys_clk) wp_n = 1'b0;
		cmd(8'h06);
		wr(8'h00);
		rd(8'h82);
		@(negedge sys_clk) wp_n = 1'b1;
		wr(8'h00);
		eng(1'b0, 1'b0);
		rd(8'h00);
		cmd(8'h06);
		cmd(8'he2);
		cmd(8'he6);
		cmd(8'he5);
		eng(1'b1, 1'b0);
		rd(8'h43);
		host_u.xfer({8'he1, 8'h00}, 16, r);
		`CHK(r, 8'h00)
		cmd(8'h04);
		rd(8'h43);
		cmd(8'h30);
		rd(8'h02);
		cmd(8'h04);
		rd(8'h00);
		cmd(8'h06);
		cmd(8'he3);
		cmd(8'he5);
		cmd(8'he6);
		eng(1'b1, 1'b0);
		rd(8'h23);
		cmd(8'h30);
		cmd(8'h04);
		cmd(8'h06);
		cmd(8'he4);
		eng(1'b1, 1'b1);
		rd(8'h00);
		cmd(8'h06);
		cmd(8'he7);
		rd(8'h00);
		`CHK(n_starts, 5)
		`CHK(n_pe, 1)
		`CHK(n_pp, 1)
		`CHK(n_sr, 1)
		stop_test();
	end
endmodule
